// ### ltc_pkg.sv
package ltc_pkg;
    // register addresses
    localparam logic [7:0] LTC_ADDR_CMD1 = 8'h00;
    localparam logic [7:0] LTC_ADDR_CMD2 = 8'h01;
    localparam logic [7:0] LTC_ADDR_DATA_LO = 8'h02;
    localparam logic [7:0] LTC_ADDR_DATA_HI = 8'h03;
    localparam logic [7:0] LTC_ADDR_LOWER_LO = 8'h04;
    localparam logic [7:0] LTC_ADDR_LOWER_HI = 8'h05;
    localparam logic [7:0] LTC_ADDR_UPPER_LO = 8'h06;
    localparam logic [7:0] LTC_ADDR_UPPER_HI = 8'h07;
    localparam logic [7:0] LTC_ADDR_TEST = 8'h08;
    // field positions
    localparam int LTC_MODE_LSB = 5;
    localparam int LTC_FLAG_BIT = 2;
    localparam int LTC_PERSIST_LSB = 0;
    localparam int LTC_RES_LSB = 2;
    localparam int LTC_RANGE_LSB = 0;
    // reset values, and the fixed test register read value
    localparam logic [7:0] LTC_RST_CMD = 8'h00;
    localparam logic [7:0] LTC_RST_DATA = 8'h00;
    localparam logic [7:0] LTC_RST_LOWER = 8'h00;
    localparam logic [7:0] LTC_RST_UPPER = 8'hff;
    localparam logic [7:0] LTC_TEST_VALUE = 8'h00;
    // operating modes
    localparam logic [2:0] LTC_MODE_OFF = 3'h0;
    localparam logic [2:0] LTC_MODE_VIS_ONCE = 3'h1;
    localparam logic [2:0] LTC_MODE_IR_ONCE = 3'h2;
    // oscillator cycles per integration, by resolution code
    localparam logic [16:0] LTC_CYC_RES16 = 17'h10000;
    localparam logic [16:0] LTC_CYC_RES12 = 17'h01000;
    localparam logic [16:0] LTC_CYC_RES8 = 17'h00100;
    localparam logic [16:0] LTC_CYC_RES4 = 17'h00010;
    // consecutive out-of-window conversions, by persist code
    localparam logic [4:0] LTC_PERSIST_1 = 5'h01;
    localparam logic [4:0] LTC_PERSIST_4 = 5'h04;
    localparam logic [4:0] LTC_PERSIST_8 = 5'h08;
    localparam logic [4:0] LTC_PERSIST_16 = 5'h10;

    typedef enum logic [1:0] {
        LTC_IDLE = 2'b01,
        LTC_RUN = 2'b10
    } ltc_state_type;
endpackage

// ### ltc_integ_timer.sv
`timescale 1ns/100ps
module ltc_integ_timer (
    input wire logic clk, // reference clock
    input wire logic rstn, // async reset, active low
    input wire logic osc_clk, // internal oscillator, unsynchronised
    input wire logic run, // conversions enabled
    input wire logic [1:0] res, // resolution code
    output logic done // one-cycle pulse at end of integration
);
    import ltc_pkg::*;

    logic s1, s2, s3;
    logic lvl, next_lvl;
    ltc_state_type state, next_state;
    logic [16:0] cnt, next_cnt;
    logic [16:0] target;
    logic next_done;
    logic osc_edge;

    // s1 feeds only s2; a level counts once s2 and s3 agree on it
    assign next_lvl = (s2 == s3) ? s3 : lvl;
    assign osc_edge = next_lvl & ~lvl;

    always_comb begin
        case (res) // [RULE11]
            2'b00: target = LTC_CYC_RES16;
            2'b01: target = LTC_CYC_RES12;
            2'b10: target = LTC_CYC_RES8;
            default: target = LTC_CYC_RES4;
        endcase
    end

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_done = 1'b0;
        case (state)
            LTC_IDLE: begin
                next_cnt = 17'h0;
                if (run) begin
                    next_state = LTC_RUN;
                end
            end
            LTC_RUN: begin
                if (!run) begin
                    next_state = LTC_IDLE;
                    next_cnt = 17'h0;
                end else if (osc_edge) begin
                    // integration lasts 2^n oscillator cycles
                    if (17'(cnt + 17'h1) >= target) begin // [RULE5]
                        next_cnt = 17'h0;
                        next_done = 1'b1;
                    end else begin
                        next_cnt = 17'(cnt + 17'h1);
                    end
                end
            end
            default: begin
                next_state = LTC_IDLE;
                next_cnt = 17'h0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            lvl <= 1'b0;
            state <= LTC_IDLE;
            cnt <= 17'h0;
            done <= 1'b0;
        end else begin
            s1 <= osc_clk;
            s2 <= s1;
            s3 <= s2;
            lvl <= next_lvl;
            state <= next_state;
            cnt <= next_cnt;
            done <= next_done;
        end
    end

    property p_done_single;
        @(posedge clk) disable iff (!rstn)
        done |=> !done;
    endproperty
    a_done_single: assert property (p_done_single) // [RULE5]
        else $error("integration done pulse longer than one cycle");

    property p_done_on_edge;
        @(posedge clk) disable iff (!rstn)
        done |-> $past(osc_edge) && $past(state == LTC_RUN);
    endproperty
    a_done_on_edge: assert property (p_done_on_edge) // [RULE5]
        else $error("integration ended without an oscillator edge");
endmodule

// ### ltc_light_compare.sv
`timescale 1ns/100ps
// Behaviour
// RULE1: result at or above upper threshold sets flag, drives pin low.
// RULE2: upper threshold is 16 bits, low byte at 0x06, high byte 0x07.
// RULE3: both upper threshold bytes reset to 0xff.
// RULE4: test register 0x08 reads zero; host leaves it alone, writes ignored.
// RULE5: integration lasts 2^n oscillator cycles, n being 4, 8, 12 or 16.
// RULE6: bits 3:2 of register 0x01 select the resolution n.
// RULE7: result limited to n bits, stored in data registers 0x02 and 0x03.
// RULE8: result at or below lower threshold sets flag and drives pin low.
// RULE9: flag and pin hold until a read of register 0x00 completes.
// RULE10: persist 00..11 needs 1, 4, 8, 16 consecutive out-of-window results.
// RULE11: resolution code 00..11 means 16, 12, 8, 4 bits.
// RULE12: compare once per finished conversion on the newly stored result.
module ltc_light_compare (
    input wire logic REF_CLK, // reference clock, 25 MHz
    input wire logic RSTN, // async reset, active low
    input wire logic OSC_CLK, // internal oscillator
    input wire logic [15:0] ADC_RESULT, // converter count at end of integration
    input wire logic [7:0] REG_ADDR, // register address
    input wire logic [7:0] REG_WDATA, // write data byte
    input wire logic REG_WR, // write strobe, one cycle
    input wire logic REG_RD, // end of a read byte transfer, one cycle
    output logic [7:0] REG_RDATA, // read data for REG_ADDR
    output logic INT_N // interrupt pin, active low
);
    import ltc_pkg::*;

    logic [2:0] mode, next_mode;
    logic [1:0] persist, next_persist;
    logic [1:0] res, next_res;
    logic [1:0] range_sel, next_range_sel;
    logic flag, next_flag;
    logic [15:0] data, next_data;
    logic [15:0] lower, next_lower;
    logic [15:0] upper, next_upper;
    logic [4:0] out_cnt, next_out_cnt;
    logic cmp_pend, next_cmp_pend;
    logic [7:0] next_rdata;
    logic next_int_n;
    logic conv_done;
    logic [15:0] res_mask;
    logic [4:0] need;
    logic [5:0] cnt_up;
    logic above, below, outside, trigger, read_clear;

    ltc_integ_timer u_timer (
        .clk(REF_CLK),
        .rstn(RSTN),
        .osc_clk(OSC_CLK),
        .run(mode != LTC_MODE_OFF),
        .res(res), // [RULE6]
        .done(conv_done)
    );

    always_comb begin
        case (res) // [RULE11]
            2'b00: res_mask = 16'hffff;
            2'b01: res_mask = 16'h0fff;
            2'b10: res_mask = 16'h00ff;
            default: res_mask = 16'h000f;
        endcase
        case (persist) // [RULE10]
            2'b00: need = LTC_PERSIST_1;
            2'b01: need = LTC_PERSIST_4;
            2'b10: need = LTC_PERSIST_8;
            default: need = LTC_PERSIST_16;
        endcase
    end

    assign above = data >= upper; // [RULE1] [RULE2]
    assign below = data <= lower; // [RULE8]
    assign outside = above | below;
    // only the pending slot after a conversion may trigger
    assign cnt_up = {1'b0, out_cnt} + 6'h01;
    assign trigger = cmp_pend && outside &&
        cnt_up >= {1'b0, need}; // [RULE12]
    assign read_clear = REG_RD && REG_ADDR == LTC_ADDR_CMD1; // [RULE9]

    always_comb begin
        next_mode = mode;
        next_persist = persist;
        next_res = res;
        next_range_sel = range_sel;
        next_data = data;
        next_lower = lower;
        next_upper = upper;
        next_out_cnt = out_cnt;
        next_cmp_pend = 1'b0;
        next_flag = flag;
        if (conv_done) begin
            next_data = ADC_RESULT & res_mask; // [RULE7]
            next_cmp_pend = 1'b1;
            if (mode == LTC_MODE_VIS_ONCE || mode == LTC_MODE_IR_ONCE) begin
                next_mode = LTC_MODE_OFF;
            end
        end
        if (cmp_pend) begin // [RULE12]
            if (!outside) begin
                next_out_cnt = 5'h0;
            end else if (out_cnt < need) begin
                // a count left above a smaller need still trips
                next_out_cnt = 5'(out_cnt + 5'h1); // [RULE10]
            end
        end
        // a new trigger outweighs a clearing read in the same cycle
        if (trigger) begin
            next_flag = 1'b1; // [RULE1] [RULE8]
        end else if (read_clear) begin
            next_flag = 1'b0; // [RULE9]
        end
        if (REG_WR) begin
            case (REG_ADDR)
                LTC_ADDR_CMD1: begin
                    next_mode = REG_WDATA[LTC_MODE_LSB +: 3];
                    next_persist = REG_WDATA[LTC_PERSIST_LSB +: 2];
                end
                LTC_ADDR_CMD2: begin
                    next_res = REG_WDATA[LTC_RES_LSB +: 2]; // [RULE6]
                    next_range_sel = REG_WDATA[LTC_RANGE_LSB +: 2];
                end
                LTC_ADDR_LOWER_LO: next_lower[7:0] = REG_WDATA;
                LTC_ADDR_LOWER_HI: next_lower[15:8] = REG_WDATA;
                LTC_ADDR_UPPER_LO: next_upper[7:0] = REG_WDATA; // [RULE2]
                LTC_ADDR_UPPER_HI: next_upper[15:8] = REG_WDATA; // [RULE2]
                default: begin
                    // data and test registers ignore writes
                end
            endcase
        end
        next_int_n = ~next_flag; // [RULE9]
    end

    always_comb begin
        case (REG_ADDR)
            LTC_ADDR_CMD1:
                next_rdata = {mode, 2'b00, flag, persist};
            LTC_ADDR_CMD2:
                next_rdata = {4'h0, res, range_sel};
            LTC_ADDR_DATA_LO: next_rdata = data[7:0]; // [RULE7]
            LTC_ADDR_DATA_HI: next_rdata = data[15:8]; // [RULE7]
            LTC_ADDR_LOWER_LO: next_rdata = lower[7:0];
            LTC_ADDR_LOWER_HI: next_rdata = lower[15:8];
            LTC_ADDR_UPPER_LO: next_rdata = upper[7:0];
            LTC_ADDR_UPPER_HI: next_rdata = upper[15:8];
            LTC_ADDR_TEST: next_rdata = LTC_TEST_VALUE; // [RULE4]
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            mode <= LTC_RST_CMD[LTC_MODE_LSB +: 3];
            persist <= LTC_RST_CMD[LTC_PERSIST_LSB +: 2];
            res <= LTC_RST_CMD[LTC_RES_LSB +: 2];
            range_sel <= LTC_RST_CMD[LTC_RANGE_LSB +: 2];
            flag <= 1'b0;
            data <= {LTC_RST_DATA, LTC_RST_DATA};
            lower <= {LTC_RST_LOWER, LTC_RST_LOWER};
            upper <= {LTC_RST_UPPER, LTC_RST_UPPER}; // [RULE3]
            out_cnt <= 5'h0;
            cmp_pend <= 1'b0;
            REG_RDATA <= 8'h00;
            INT_N <= 1'b1;
        end else begin
            mode <= next_mode;
            persist <= next_persist;
            res <= next_res;
            range_sel <= next_range_sel;
            flag <= next_flag;
            data <= next_data;
            lower <= next_lower;
            upper <= next_upper;
            out_cnt <= next_out_cnt;
            cmp_pend <= next_cmp_pend;
            REG_RDATA <= next_rdata;
            INT_N <= next_int_n;
        end
    end

    property p_upper_trip;
        @(posedge REF_CLK) disable iff (!RSTN)
        cmp_pend && data >= upper && persist == 2'b00 |=> flag && !INT_N;
    endproperty
    a_upper_trip: assert property (p_upper_trip) // [RULE1]
        else $error("upper threshold hit did not raise interrupt");

    property p_lower_trip;
        @(posedge REF_CLK) disable iff (!RSTN)
        cmp_pend && data <= lower && persist == 2'b00 |=> flag && !INT_N;
    endproperty
    a_lower_trip: assert property (p_lower_trip) // [RULE8]
        else $error("lower threshold hit did not raise interrupt");

    property p_hold_until_read;
        @(posedge REF_CLK) disable iff (!RSTN)
        flag && !(REG_RD && REG_ADDR == LTC_ADDR_CMD1) |=> flag;
    endproperty
    a_hold_until_read: assert property (p_hold_until_read) // [RULE9]
        else $error("interrupt flag dropped without a read");

    property p_read_clears;
        @(posedge REF_CLK) disable iff (!RSTN)
        flag && REG_RD && REG_ADDR == LTC_ADDR_CMD1 && !cmp_pend
            |=> !flag ##0 INT_N;
    endproperty
    a_read_clears: assert property (p_read_clears) // [RULE9]
        else $error("status read did not clear interrupt");

    property p_test_zero;
        @(posedge REF_CLK) disable iff (!RSTN)
        REG_ADDR == LTC_ADDR_TEST |=> REG_RDATA == 8'h00;
    endproperty
    a_test_zero: assert property (p_test_zero) // [RULE4]
        else $error("test register read nonzero");

    property p_upper_read;
        @(posedge REF_CLK) disable iff (!RSTN)
        RSTN && REG_ADDR == LTC_ADDR_UPPER_HI
            |=> REG_RDATA == $past(upper[15:8]);
    endproperty
    a_upper_read: assert property (p_upper_read) // [RULE2]
        else $error("upper threshold high byte read wrong");

    property p_cmp_after_conv;
        @(posedge REF_CLK) disable iff (!RSTN)
        $rose(flag) |-> $past(cmp_pend) && $past(conv_done, 2);
    endproperty
    a_cmp_after_conv: assert property (p_cmp_after_conv) // [RULE12]
        else $error("flag set outside a finished conversion");

    property p_mask_4bit;
        @(posedge REF_CLK) disable iff (!RSTN)
        conv_done && res == 2'b11 |=> data[15:4] == 12'h000;
    endproperty
    a_mask_4bit: assert property (p_mask_4bit) // [RULE7]
        else $error("4-bit result has high bits set");

    property p_persist_four;
        @(posedge REF_CLK) disable iff (!RSTN)
        !flag && cmp_pend && persist == 2'b01 && out_cnt == 5'h0
            |=> !flag;
    endproperty
    a_persist_four: assert property (p_persist_four) // [RULE10]
        else $error("persist of four tripped on first result");

    property p_res_decode;
        @(posedge REF_CLK) disable iff (!RSTN)
        REG_WR && REG_ADDR == LTC_ADDR_CMD2 |=> res == $past(REG_WDATA[3:2]);
    endproperty
    a_res_decode: assert property (p_res_decode) // [RULE6]
        else $error("resolution field not taken from bits 3:2");
endmodule

// ### ltc_host_model.sv
`timescale 1ns/100ps
module ltc_host_model (
    input wire logic clk, // reference clock
    output logic [7:0] addr, // register address
    output logic [7:0] wdata, // write byte
    output logic wr, // write strobe
    output logic rd, // end of a read byte
    input wire logic [7:0] rdata // read data from the device
);
    import ltc_pkg::*;
    bit slow = 1'b0;
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // a slow host idles before each request
    task automatic pace();
        if (slow) begin
            repeat (3) @(posedge clk);
        end
    endtask
    // never aimed at the test register by any caller
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        pace();
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    // byte taken with the address held, then the transfer ends
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        pace();
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        @(posedge clk);
        d = rdata;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic point(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
    endtask
    // resolution sits in bits 3:2 of the second command byte
    task automatic set_res(input logic [1:0] r);
        write(LTC_ADDR_CMD2, {4'h0, r, 2'b00});
    endtask
endmodule

// ### light_threshold_interrupt_compare_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
end

module light_threshold_interrupt_compare_test;
    import ltc_pkg::*;
    typedef struct packed {
        logic [1:0] res;
        logic [15:0] adc;
        logic [15:0] lower;
        logic [15:0] upper;
        logic [15:0] data;
        logic int_n;
    } ltc_row_type;
    logic REF_CLK = 1'b0;
    logic OSC_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic [15:0] ADC_RESULT = 16'h0000;
    logic [7:0] REG_ADDR;
    logic [7:0] REG_WDATA;
    logic [7:0] REG_RDATA;
    logic REG_WR;
    logic REG_RD;
    logic INT_N;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    int cyc;
    int lo;
    int hi;
    int need;
    ltc_row_type rows [5] = '{
        '{2'b11, 16'hfff5, 16'h0002, 16'h000c, 16'h0005, 1'b1},
        '{2'b11, 16'h000c, 16'h0002, 16'h000c, 16'h000c, 1'b0},
        '{2'b10, 16'h1202, 16'h0002, 16'h00f0, 16'h0002, 1'b0},
        '{2'b10, 16'h12ef, 16'h0002, 16'h00f0, 16'h00ef, 1'b1},
        '{2'b01, 16'hf9e7, 16'h0100, 16'h0a00, 16'h09e7, 1'b1}
    };

    always #20 REF_CLK = ~REF_CLK;
    initial begin
        #53;
        forever #160 OSC_CLK = ~OSC_CLK;
    end

    ltc_light_compare uut (
        .REF_CLK(REF_CLK),
        .RSTN(RSTN),
        .OSC_CLK(OSC_CLK),
        .ADC_RESULT(ADC_RESULT),
        .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR),
        .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA),
        .INT_N(INT_N)
    );
    ltc_host_model host (
        .clk(REF_CLK),
        .addr(REG_ADDR),
        .wdata(REG_WDATA),
        .wr(REG_WR),
        .rd(REG_RD),
        .rdata(REG_RDATA)
    );

    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge REF_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic chk_reg(input string nm, input logic [7:0] a,
                           input logic [7:0] e);
        logic [7:0] v;
        host.read(a, v);
        `CHK(nm, e, v)
    endtask
    task automatic in_range(input string nm, input int lo, input int hi,
                            input int n);
        `CHK(nm, 1'b1, (n >= lo && n <= hi))
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        host.write(a, v[7:0]);
        host.write(a + 8'h01, v[15:8]);
    endtask
    // one conversion; counts cycles until the mode field reads back idle
    task automatic conv(input logic [1:0] res, input logic [15:0] adc,
                        output int n);
        @(posedge REF_CLK);
        ADC_RESULT <= adc;
        host.set_res(res);
        host.write(LTC_ADDR_CMD1, 8'h20);
        host.point(LTC_ADDR_CMD1);
        n = 0;
        while ((n < 3 || REG_RDATA[7:5] !== 3'h0) && n < 40000) begin
            @(posedge REF_CLK);
            n++;
        end
        repeat (2) @(posedge REF_CLK);
    endtask

    initial begin
        repeat (5) @(posedge REF_CLK);
        `CHK("pin in reset", 1'b1, INT_N)
        `CHK("rdata in reset", 8'h00, REG_RDATA)
        RSTN <= 1'b1;
        chk_reg("upper lo reset", LTC_ADDR_UPPER_LO, 8'hff);
        chk_reg("upper hi reset", LTC_ADDR_UPPER_HI, 8'hff);
        chk_reg("test register", LTC_ADDR_TEST, 8'h00);
        chk_reg("resolution reset", LTC_ADDR_CMD2, 8'h00);
        chk_reg("unmapped", 8'h20, 8'h00);
        host.write(LTC_ADDR_CMD1, 8'h04);
        chk_reg("flag read only", LTC_ADDR_CMD1, 8'h00);
        foreach (rows[i]) begin
            wr16(LTC_ADDR_LOWER_LO, rows[i].lower);
            wr16(LTC_ADDR_UPPER_LO, rows[i].upper);
            conv(rows[i].res, rows[i].adc, cyc);
            lo = (8 << (16 - 4 * rows[i].res)) - 8;
            in_range("integration", lo, lo + 24, cyc);
            chk_reg("data lo", LTC_ADDR_DATA_LO, rows[i].data[7:0]);
            chk_reg("data hi", LTC_ADDR_DATA_HI, rows[i].data[15:8]);
            `CHK("pin", rows[i].int_n, INT_N)
            chk_reg("flag", LTC_ADDR_CMD1,
                    {5'h0, ~rows[i].int_n, 2'b00});
            repeat (2) @(posedge REF_CLK);
            `CHK("pin cleared", 1'b1, INT_N)
        end
        // a threshold change with no conversion running must not trigger
        host.write(LTC_ADDR_UPPER_HI, 8'h00);
        repeat (40) @(posedge REF_CLK);
        `CHK("idle compare", 1'b1, INT_N)
        wr16(LTC_ADDR_LOWER_LO, 16'h0002);
        wr16(LTC_ADDR_UPPER_LO, 16'h000c);
        host.slow = 1'b1;
        for (int p = 0; p < 4; p++) begin
            conv(2'b11, 16'h0005, cyc);
            need = (p == 0) ? 1 : (2 << p);
            lo = need * 128 - 8;
            hi = need * 136 + 16;
            @(posedge REF_CLK);
            ADC_RESULT <= 16'h000e;
            host.write(LTC_ADDR_CMD1, {3'b101, 3'b000, p[1:0]});
            cyc = 0;
            while (INT_N !== 1'b0 && cyc < 3000) begin
                @(posedge REF_CLK);
                cyc++;
            end
            in_range("persist", lo, hi, cyc);
            host.write(LTC_ADDR_CMD1, 8'h00);
            repeat (200) @(posedge REF_CLK);
            `CHK("pin holds", 1'b0, INT_N)
            chk_reg("flag held", LTC_ADDR_CMD1, 8'h04);
            repeat (2) @(posedge REF_CLK);
            `CHK("pin cleared", 1'b1, INT_N)
        end
        // ir once, with the count left saturated by persist sixteen
        @(posedge REF_CLK);
        ADC_RESULT <= 16'h000e;
        host.write(LTC_ADDR_CMD1, 8'h40);
        repeat (200) @(posedge REF_CLK);
        `CHK("ir once pin", 1'b0, INT_N)
        host.write(LTC_ADDR_UPPER_HI, 8'h12);
        chk_reg("ir once status", LTC_ADDR_CMD1, 8'h04);
        // reset again in mid-run
        @(posedge REF_CLK);
        RSTN <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        `CHK("rdata in mid reset", 8'h00, REG_RDATA)
        RSTN <= 1'b1;
        chk_reg("upper hi after reset", LTC_ADDR_UPPER_HI, 8'hff);
        chk_reg("data after reset", LTC_ADDR_DATA_LO, 8'h00);
        final_report();
    end
endmodule
